// ===== rtl/embc_bus_engine.sv
// embc_bus_engine: external bus cycle sequencer for generic memory and DRAM
// assumes a synchronous request/accept port from the core and wait in sync with core_clk
`timescale 1ns/1ps
module embc_bus_engine
	import embc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_fetch,
	input wire logic req_word,
	input wire logic req_bus16,
	input wire logic req_dram,
	input wire logic [2:0] req_cs,
	input wire logic [EMBC_ADDR_W-1:0] req_addr,
	input wire logic [EMBC_DATA_W-1:0] req_wdata,
	input wire logic [4:0] req_burst_len,
	input wire logic [3:0] req_strobe_clks,
	input wire logic [3:0] precharge_clks,
	input wire logic wait_in,
	input wire logic [EMBC_DATA_W-1:0] data_in,
	output logic req_ready,
	output logic rd_valid,
	output logic [EMBC_DATA_W-1:0] rd_data,
	output logic [EMBC_ADDR_W-1:0] addr_out,
	output logic [EMBC_DATA_W-1:0] data_out,
	output logic data_oe,
	output logic chip_select_n,
	output logic [EMBC_NUM_CS-1:0] row_strobe_n,
	output logic low_lane_column_strobe,
	output logic high_lane_column_strobe,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic bus_clock_output
);
	embc_state_t state, next_state;
	logic write, next_write, fetch, next_fetch, word, next_word, bus16, next_bus16;
	logic dram, next_dram;
	logic [2:0] cs, next_cs;
	logic [3:0] strobe_clks, next_strobe_clks, ws, next_ws;
	logic [4:0] remain, next_remain;
	logic [EMBC_ADDR_W-1:0] next_addr_out;
	logic [EMBC_DATA_W-1:0] next_data_out, next_rd_data;
	logic next_data_oe, next_chip_select_n, next_req_ready, next_rd_valid;
	logic [EMBC_NUM_CS-1:0] next_row_strobe_n;
	logic next_low, next_high, next_oe_n, next_we_n, next_clk_out;
	logic [EMBC_NUM_CS-1:0] row_release, pre_busy;

	// lane enable pair {high, low} for an access
	function automatic logic [1:0] lanes(input logic is_bus16, input logic is_word,
		input logic a0);
		if (!is_bus16) begin
			lanes = 2'h1;
		end else if (is_word) begin
			lanes = 2'h3;
		end else begin
			lanes = a0 ? 2'h2 : 2'h1;
		end
	endfunction

	// ---------------------------------------------------------------
	// precharge timers, one per row strobe
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < EMBC_NUM_CS; gi++) begin : g_pre
			assign row_release[gi] = !row_strobe_n[gi] && next_row_strobe_n[gi];
			embc_precharge u_pre (
				.core_clk(core_clk),
				.reset(reset),
				.row_release(row_release[gi]),
				.precharge_clks(precharge_clks),
				.busy(pre_busy[gi])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb begin
		logic [1:0] ln;
		ln = 2'h0;
		next_state = state;
		next_write = write;
		next_fetch = fetch;
		next_word = word;
		next_bus16 = bus16;
		next_dram = dram;
		next_cs = cs;
		next_strobe_clks = strobe_clks;
		next_ws = ws;
		next_remain = remain;
		next_addr_out = addr_out;
		next_data_out = data_out;
		next_rd_data = rd_data;
		next_data_oe = data_oe;
		next_chip_select_n = chip_select_n;
		next_row_strobe_n = row_strobe_n;
		next_low = low_lane_column_strobe;
		next_high = high_lane_column_strobe;
		next_oe_n = output_enable_n;
		next_we_n = write_enable_n;
		next_req_ready = 1'b0;
		next_rd_valid = 1'b0;
		next_clk_out = !bus_clock_output;
		case (state)
			EMBC_IDLE: begin
				next_req_ready = 1'b1;
				if (req_valid && req_ready) begin
					next_req_ready = 1'b0;
					next_write = req_write && !req_fetch;
					next_fetch = req_fetch;
					next_word = req_word || req_fetch;
					next_bus16 = req_bus16;
					next_dram = req_dram;
					next_cs = (req_cs < 3'(EMBC_NUM_CS)) ? req_cs : 3'h0;
					// clamp timings to workable values
					next_strobe_clks = (req_strobe_clks == EMBC_WS_ZERO) ? EMBC_LO_ONE
						: req_strobe_clks;
					if (req_fetch) begin
						if (req_burst_len < EMBC_LEN_MIN) begin
							next_remain = EMBC_LEN_MIN;
						end else if (req_burst_len > EMBC_LEN_MAX) begin
							next_remain = EMBC_LEN_MAX;
						end else begin
							next_remain = req_burst_len;
						end
						// 16-bit bursts count bytes down two at a time; an odd length ends on the wrap
					end else begin
						next_remain = req_bus16 ? EMBC_LEN_TWO : EMBC_LEN_ONE;
					end
					next_addr_out = req_addr;
					if (req_bus16 && req_fetch) begin
						next_addr_out[0] = 1'b0;
					end
					next_data_out = req_wdata;
					next_state = EMBC_SETUP;
				end
			end
			EMBC_SETUP: begin
				if (!(dram && pre_busy[cs])) begin
					next_chip_select_n = dram;
					if (dram) begin
						next_row_strobe_n[cs] = 1'b0;
					end
					next_data_oe = write;
					next_state = EMBC_STROBE;
					next_ws = strobe_clks;
					ln = lanes(bus16, word, addr_out[0]);
					next_low = ln[0];
					next_high = ln[1];
					next_oe_n = write;
					next_we_n = !write;
				end
			end
			EMBC_STROBE: begin
				if (ws != EMBC_WS_ZERO) begin
					next_ws = ws - EMBC_LO_ONE;
				end else if (!wait_in) begin
					next_rd_data = data_in;
					next_rd_valid = !write;
					next_low = 1'b0;
					next_high = 1'b0;
					next_we_n = 1'b1;
					next_state = EMBC_RECOVER;
					next_remain = remain - (bus16 ? EMBC_LEN_TWO : EMBC_LEN_ONE);
				end
			end
			EMBC_RECOVER: begin
				if (fetch && remain != 5'h00 && !remain[4]) begin
					if (bus16) begin
						next_addr_out[3:1] = addr_out[3:1] + 3'h1;
					end else begin
						next_addr_out[3:0] = addr_out[3:0] + 4'h1;
					end
					// keep output enable low between beats, so data hold relies on the memory
					ln = lanes(bus16, word, 1'b0);
					next_low = ln[0];
					next_high = ln[1];
					next_ws = strobe_clks;
					next_state = EMBC_STROBE;
				end else begin
					next_chip_select_n = 1'b1;
					next_row_strobe_n = {EMBC_NUM_CS{1'b1}};
					next_oe_n = 1'b1;
					next_data_oe = 1'b0;
					next_state = EMBC_PRECHARGE;
				end
			end
			EMBC_PRECHARGE: begin
				next_state = EMBC_IDLE;
			end
			default: begin
				next_state = EMBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= EMBC_IDLE;
			write <= 1'b0;
			fetch <= 1'b0;
			word <= 1'b0;
			bus16 <= 1'b0;
			dram <= 1'b0;
			cs <= 3'h0;
			strobe_clks <= EMBC_LO_ONE;
			ws <= EMBC_WS_ZERO;
			remain <= 5'h00;
			addr_out <= '0;
			data_out <= '0;
			rd_data <= '0;
			data_oe <= 1'b0;
			chip_select_n <= 1'b1;
			row_strobe_n <= {EMBC_NUM_CS{1'b1}};
			low_lane_column_strobe <= 1'b0;
			high_lane_column_strobe <= 1'b0;
			output_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
			req_ready <= 1'b0;
			rd_valid <= 1'b0;
			bus_clock_output <= 1'b0;
		end else begin
			state <= next_state;
			write <= next_write;
			fetch <= next_fetch;
			word <= next_word;
			bus16 <= next_bus16;
			dram <= next_dram;
			cs <= next_cs;
			strobe_clks <= next_strobe_clks;
			ws <= next_ws;
			remain <= next_remain;
			addr_out <= next_addr_out;
			data_out <= next_data_out;
			rd_data <= next_rd_data;
			data_oe <= next_data_oe;
			chip_select_n <= next_chip_select_n;
			row_strobe_n <= next_row_strobe_n;
			low_lane_column_strobe <= next_low;
			high_lane_column_strobe <= next_high;
			output_enable_n <= next_oe_n;
			write_enable_n <= next_we_n;
			req_ready <= next_req_ready;
			rd_valid <= next_rd_valid;
			bus_clock_output <= next_clk_out;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_row_rise(int i);
		!row_strobe_n[i] ##1 row_strobe_n[i];
	endsequence

	high_lane_off_a: assert property (@(posedge core_clk) disable iff (reset)
		!bus16 && state != EMBC_IDLE |-> !high_lane_column_strobe)
		else $error("high lane strobe on 8-bit bus");
	low_lane_on_a: assert property (@(posedge core_clk) disable iff (reset)
		state == EMBC_SETUP && !bus16 && !(dram && pre_busy[cs]) |=> low_lane_column_strobe)
		else $error("low lane strobe missing on 8-bit bus");
	single_lane_a: assert property (@(posedge core_clk) disable iff (reset)
		state == EMBC_STROBE && bus16 && !word |-> !(low_lane_column_strobe
		&& high_lane_column_strobe))
		else $error("both lanes for a byte write");
	odd_lane_a: assert property (@(posedge core_clk) disable iff (reset)
		state == EMBC_STROBE && bus16 && !word && addr_out[0] |-> high_lane_column_strobe)
		else $error("odd byte not on high lane");
	word_step_a: assert property (@(posedge core_clk) disable iff (reset)
		state == EMBC_RECOVER && fetch && bus16 && next_state == EMBC_STROBE
		|=> addr_out[3:1] == $past(addr_out[3:1]) + 3'h1
		&& addr_out[EMBC_ADDR_W-1:4] == $past(addr_out[EMBC_ADDR_W-1:4]))
		else $error("16-bit burst address step wrong");
	byte_step_a: assert property (@(posedge core_clk) disable iff (reset)
		state == EMBC_RECOVER && fetch && !bus16 && next_state == EMBC_STROBE
		|=> addr_out[3:0] == $past(addr_out[3:0]) + 4'h1)
		else $error("8-bit burst address step wrong");
	row_high_two_a: assert property (@(posedge core_clk) disable iff (reset)
		s_row_rise(0) |-> row_strobe_n[0] [*2])
		else $error("row strobe high under two clocks");
	burst_len_a: assert property (@(posedge core_clk) disable iff (reset)
		state == EMBC_IDLE && next_state == EMBC_SETUP && req_fetch
		|=> remain >= EMBC_LEN_MIN && remain <= EMBC_LEN_MAX)
		else $error("burst length out of range");
	wait_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		state == EMBC_STROBE && wait_in |=> state == EMBC_STROBE)
		else $error("cycle ended while wait asserted");
	oe_on_read_a: assert property (@(posedge core_clk) disable iff (reset)
		data_oe |-> output_enable_n)
		else $error("data driven while output enable low");
endmodule

// ===== rtl/embc_pkg.sv
// embc_pkg: constants and types shared by the external memory bus cycle engine
// assumes a single 40 MHz core clock; no software-visible registers
package embc_pkg;
	localparam int EMBC_ADDR_W = 24;
	localparam int EMBC_DATA_W = 16;
	localparam int EMBC_NUM_CS = 5;
	localparam int EMBC_CLK_PERIOD_NS = 25;
	localparam int EMBC_MIN_PRECHARGE_CLKS = 2;
	localparam int EMBC_MIN_BURST_BYTES = 2;
	localparam int EMBC_MAX_BURST_BYTES = 16;
	localparam logic [3:0] EMBC_PRE_MIN = 4'h2;
	localparam logic [3:0] EMBC_PRE_ZERO = 4'h0;
	localparam logic [3:0] EMBC_PRE_ONE = 4'h1;
	localparam logic [4:0] EMBC_LEN_MIN = 5'h02;
	localparam logic [4:0] EMBC_LEN_MAX = 5'h10;
	localparam logic [4:0] EMBC_LEN_ONE = 5'h01;
	localparam logic [4:0] EMBC_LEN_TWO = 5'h02;
	localparam logic [3:0] EMBC_LO_ONE = 4'h1;
	localparam logic [3:0] EMBC_LO_TWO = 4'h2;
	localparam logic [3:0] EMBC_WS_ZERO = 4'h0;

	typedef enum logic [2:0] {
		EMBC_IDLE = 3'b000,
		EMBC_SETUP = 3'b001,
		EMBC_STROBE = 3'b010,
		EMBC_RECOVER = 3'b011,
		EMBC_PRECHARGE = 3'b100
	} embc_state_t;
endpackage

// ===== rtl/embc_precharge.sv
// embc_precharge: per row-strobe precharge counter
// assumes one pulse on row_release when the row strobe goes high
`timescale 1ns/1ps
module embc_precharge
	import embc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic row_release,
	input wire logic [3:0] precharge_clks,
	output logic busy
);
	logic [3:0] count;
	logic [3:0] next_count;
	logic [3:0] load_value;

	// ---------------------------------------------------------------
	// count
	// ---------------------------------------------------------------
	always_comb begin
		// floor of two clocks whatever is programmed
		load_value = (precharge_clks < EMBC_PRE_MIN) ? EMBC_PRE_MIN : precharge_clks;
		next_count = count;
		if (row_release) begin
			next_count = load_value - EMBC_PRE_ONE;
		end else if (count != EMBC_PRE_ZERO) begin
			next_count = count - EMBC_PRE_ONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			count <= EMBC_PRE_ZERO;
		end else begin
			count <= next_count;
		end
	end

	assign busy = (count != EMBC_PRE_ZERO);

	floor_two_clks_a: assert property (@(posedge core_clk) disable iff (reset)
		row_release |=> busy)
		else $error("precharge shorter than two clocks");
endmodule

// ===== tb/embc_mem_model.sv
// embc_mem_model: behavioural external memory on the far side of the bus engine
// assumes the engine's registered address and active low output enable
`timescale 1ns/1ps
module embc_mem_model (
	input wire logic core_clk,
	input wire logic [23:0] addr_out,
	input wire logic output_enable_n,
	output logic [15:0] data_in
);
	logic [15:0] last;
	logic driving;

	// -----------------------------
	// read data path
	// -----------------------------
	// drives only while output enable is low; holds until it rises
	assign driving = (output_enable_n === 1'b0);
	// released bus shows the inverse of the last value so stale data never matches
	assign data_in = driving ? (addr_out[15:0] ^ 16'h5A3C) : ~last;
	always @(posedge core_clk) begin
		if (driving) begin
			last <= addr_out[15:0] ^ 16'h5A3C;
		end
	end
	initial last = 16'h0000;
endmodule

// ===== tb/test_embc_bus_engine.sv
// test_embc_bus_engine: self-checking bench for the external bus cycle engine
// assumes the memory model answers reads; inputs change on the falling clock edge
`timescale 1ns/1ps
module test_embc_bus_engine;
	import embc_pkg::*;
	logic core_clk = 0, reset = 1, req_valid = 0, req_write = 0, req_fetch = 0, req_word = 0;
	logic req_bus16 = 0, req_dram = 0, wait_in = 0, cur_write = 0;
	logic [2:0] req_cs = 3'h0;
	logic [23:0] req_addr = 24'h000000;
	logic [15:0] req_wdata = 16'h0000, data_in;
	logic [4:0] req_burst_len = 5'h02;
	logic [3:0] req_strobe_clks = 4'h0, precharge_clks = 4'h0;
	logic req_ready, rd_valid, data_oe, chip_select_n, low_lane, high_lane;
	logic output_enable_n, write_enable_n;
	logic [15:0] rd_data, data_out;
	logic [23:0] addr_out;
	logic [4:0] row_strobe_n, prev_row;
	logic [1:0] exp_lanes;
	logic [15:0] exp_q[$];
	int n_errors = 0, tests_run = 0, hi_cnt[5], min_pre;
	logic clk_out, exp_clk;
	logic [5:0] exp_sel;
	logic [15:0] cur_wdata;
	logic [4:0] fetch_lens[5] = '{5'h01, 5'h02, 5'h07, 5'h10, 5'h1F};

	always #12.5 core_clk = ~core_clk;

	embc_bus_engine embc_bus_engine_inst (.core_clk(core_clk), .reset(reset),
		.req_valid(req_valid), .req_write(req_write), .req_fetch(req_fetch),
		.req_word(req_word), .req_bus16(req_bus16), .req_dram(req_dram), .req_cs(req_cs),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_burst_len(req_burst_len),
		.req_strobe_clks(req_strobe_clks), .precharge_clks(precharge_clks),
		.wait_in(wait_in), .data_in(data_in), .req_ready(req_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
		.chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
		.low_lane_column_strobe(low_lane), .high_lane_column_strobe(high_lane),
		.output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
		.bus_clock_output(clk_out));
	embc_mem_model embc_mem_model_inst (.core_clk(core_clk), .addr_out(addr_out),
		.output_enable_n(output_enable_n), .data_in(data_in));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// -----------------------------
	// one bus operation with its expected read beats
	// -----------------------------
	task automatic do_op(input logic wr, fe, wd, b16, dr, input logic [2:0] cs,
		input logic [23:0] a, input logic [4:0] len, input logic [3:0] pre);
		int n, i;
		logic [23:0] ba;
		n = (len < 2) ? 2 : ((len > 16) ? 16 : len);
		if (b16) n = (n + 1) / 2;
		if (!fe) n = 1;
		for (i = 0; i < n; i++) begin
			ba = a;
			if (fe && b16) ba[3:0] = {a[3:1] + 3'(i), 1'b0};
			if (fe && !b16) ba[3:0] = a[3:0] + 4'(i);
			if (!wr || fe) exp_q.push_back(ba[15:0] ^ 16'h5A3C);
		end
		exp_lanes = !b16 ? 2'b01 : ((fe || wd) ? 2'b11 : (a[0] ? 2'b10 : 2'b01));
		cur_write = wr && !fe;
		min_pre = (pre < 2) ? 2 : pre;
		exp_sel = dr ? {1'b1, ~(5'h01 << ((cs < 3'(EMBC_NUM_CS)) ? cs : 3'h0))} : 6'h1F;
		{req_write, req_fetch, req_word, req_bus16, req_dram} = {wr, fe, wd, b16, dr};
		{req_cs, req_addr, req_burst_len, precharge_clks} = {cs, a, len, pre};
		req_wdata = 16'($urandom);
		cur_wdata = req_wdata;
		req_strobe_clks = 4'($urandom_range(0, 2));
		req_valid = 1;
		for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge core_clk);
		if (i == 100) begin
			check(1'b0, 1'b1, "request not taken");
			final_report();
		end
		@(negedge core_clk);
		req_valid = 0;
		for (i = 0; i < 300 && req_ready !== 1'b1; i++) @(negedge core_clk);
		if (i == 300) begin
			check(1'b0, 1'b1, "operation hung");
			final_report();
		end
	endtask

	// -----------------------------
	// watchers
	// -----------------------------
	always @(posedge core_clk) begin
		if (!reset && rd_valid === 1'b1 && !cur_write) begin
			if (exp_q.size() == 0) check(1'b1, 1'b0, "unexpected read beat");
			else check(rd_data, exp_q.pop_front(), "read beat data");
		end
		if (!reset && (output_enable_n === 1'b0 || write_enable_n === 1'b0)
			&& (low_lane | high_lane) !== 1'b0) begin
			check({high_lane, low_lane}, exp_lanes, "lane strobes");
		end
		if (!reset && (output_enable_n === 1'b0 || write_enable_n === 1'b0)) begin
			check(16'({chip_select_n, row_strobe_n}), 16'(exp_sel), "selects");
			check(16'(data_oe), 16'(write_enable_n === 1'b0), "bus drive");
		end
		if (!reset && write_enable_n === 1'b0) check(data_out, cur_wdata, "write data");
		if (!reset) check(16'(clk_out), 16'(exp_clk), "clock output");
		exp_clk <= reset ? 1'b0 : !exp_clk;
		for (int k = 0; k < 5; k++) begin
			if (reset) hi_cnt[k] <= 0;
			else if (row_strobe_n[k] === 1'b1) hi_cnt[k] <= hi_cnt[k] + 1;
			else begin
				if (prev_row[k] === 1'b1 && hi_cnt[k] > 0 && hi_cnt[k] < 50)
					check(16'(hi_cnt[k] >= min_pre), 16'h0001, "row precharge");
				hi_cnt[k] <= 0;
			end
		end
		prev_row <= row_strobe_n;
	end

	// random wait stretching during the strobe phase
	always @(negedge core_clk) wait_in <= (!reset && $urandom_range(0, 3) == 0);

	// -----------------------------
	// main sequence
	// -----------------------------
	initial begin
		logic [23:0] ra;
		void'($urandom(14292));
		repeat (2) @(negedge core_clk);
		reset = 0;
		// generic word read, byte writes on both lanes, 8-bit byte accesses
		do_op(0, 0, 1, 1, 0, 0, 24'h001230, 2, 0);
		do_op(1, 0, 0, 1, 0, 0, 24'h001232, 2, 0);
		do_op(1, 0, 0, 1, 0, 0, 24'h001233, 2, 0);
		do_op(0, 0, 0, 0, 0, 0, 24'h004561, 2, 0);
		do_op(1, 0, 1, 0, 0, 0, 24'h004562, 2, 0);
		// fetch lengths below, at and beyond the burst bounds on both bus widths
		foreach (fetch_lens[j]) begin
			ra = 24'($urandom);
			do_op(0, 1, 1, 1, 0, 0, ra, fetch_lens[j], 0);
			do_op(0, 1, 0, 0, 0, 0, ra, fetch_lens[j], 0);
		end
		// back-to-back DRAM rows on every row strobe, precharge settings below and above floor
		for (int c = 0; c < 6; c++) begin
			do_op(0, 0, 1, 1, 1, 3'(c), 24'($urandom), 2, 4'(c * 3));
			do_op(0, 1, 1, c[0], 1, 3'(c), 24'($urandom), 8, 4'(c * 3));
		end
		repeat (5) @(negedge core_clk);
		check(16'(exp_q.size()), 16'h0000, "missing read beats");
		final_report();
	end
endmodule
